// ### qr_valley_switch_control.sv
// valley switching flyback control: start-up, soft-start, valley choice, overvoltage latch
`timescale 1ns/1ps
`default_nettype none
`include "qr_map.svh"
module qr_valley_switch_control #(
  parameter int SS_STEP_CYC = (`QR_SS_TIME_US * `QR_CLK_MHZ) / `QR_SS_STEPS,
  parameter int PERIOD_CYC = `QR_PERIOD_US * `QR_CLK_MHZ,
  parameter int MAX_OFF_CYC = (`QR_MAX_OFF_NS * `QR_CLK_MHZ) / 1000,
  parameter int MAX_ON_CYC = (`QR_MAX_ON_NS * `QR_CLK_MHZ) / 1000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire qr_pkg::sense_t sense,
  output logic startup_cell_on,
  output logic gate_drive_output,
  output logic [9:0] cs_limit_mv,
  output logic softstart_done,
  output logic thr_line_high,
  output logic latched_off,
  output logic [2:0] ud_value,
  output logic [2:0] zc_count
);
  // minimum times round up, longest times round down
  localparam int RING_CYC = (`QR_RING_SUP_NS * `QR_CLK_MHZ + 999) / 1000;
  localparam int LEB_CYC = (`QR_LEB_NS * `QR_CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (`QR_OVP_BLANK_NS * `QR_CLK_MHZ + 999) / 1000;
  localparam int SSW = $clog2(SS_STEP_CYC + 1);
  localparam int PW = $clog2(PERIOD_CYC + 1);
  localparam int GMAX = (MAX_OFF_CYC > MAX_ON_CYC) ? MAX_OFF_CYC : MAX_ON_CYC;
  localparam int GW = $clog2(GMAX + 1);
  localparam int OW = $clog2(BLANK_CYC + 1);
  localparam logic [SSW-1:0] SS_LAST = SSW'(SS_STEP_CYC - 1);
  localparam logic [PW-1:0] PER_LAST = PW'(PERIOD_CYC - 1);
  localparam logic [GW-1:0] OFF_LAST = GW'(MAX_OFF_CYC - 1);
  localparam logic [GW-1:0] ON_LAST = GW'(MAX_ON_CYC - 1);
  localparam logic [GW-1:0] RING_LAST = GW'(RING_CYC - 1);
  localparam logic [GW-1:0] LEB_LAST = GW'(LEB_CYC - 1);
  localparam logic [OW-1:0] BLANK_LAST = OW'(BLANK_CYC - 1);

  if (SS_STEP_CYC < 1 || PERIOD_CYC < 2 || MAX_OFF_CYC <= RING_CYC ||
      MAX_ON_CYC <= LEB_CYC || BLANK_CYC < 1) begin : g_bad_timing
    $error("timing parameters out of range");
  end

  function automatic logic [9:0] lim_mv(input logic [1:0] step);
    case (step)
      2'h0: lim_mv = `QR_LIM_MV0;
      2'h1: lim_mv = `QR_LIM_MV1;
      2'h2: lim_mv = `QR_LIM_MV2;
      default: lim_mv = `QR_LIM_MV3;
    endcase
  endfunction

  // ==========================================================
  // reset release and input synchronisers
  logic [1:0] rst_pipe;
  logic [1:0] next_rst_pipe;
  logic rst_sync_b;
  logic [7:0] sync_q;
  qr_pkg::sense_t s;

  always_comb begin
    next_rst_pipe = {rst_pipe[0], 1'b1};
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= next_rst_pipe;
    end
  end

  assign rst_sync_b = rst_pipe[1];

  pin_sync #(.W(8)) u_sync (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .d_async(sense),
    .q(sync_q)
  );

  assign s = qr_pkg::sense_t'(sync_q);

  // ==========================================================
  // gate state, shared by the other groups
  qr_pkg::gate_state_t state;
  qr_pkg::gate_state_t next_state;
  logic running;

  assign running = (state == qr_pkg::ST_ON) || (state == qr_pkg::ST_OFF);

  // ==========================================================
  // soft-start ramp of the peak current limit
  logic [SSW-1:0] ss_cnt;
  logic [SSW-1:0] next_ss_cnt;
  logic [1:0] ss_step;
  logic [1:0] next_ss_step;
  logic next_ss_done;

  always_comb begin
    next_ss_cnt = ss_cnt;
    next_ss_step = ss_step;
    next_ss_done = softstart_done;
    if (running && !softstart_done) begin
      if (ss_cnt == SS_LAST) begin
        next_ss_cnt = '0;
        if (ss_step == 2'h3) begin
          next_ss_done = 1'b1;
        end else begin
          next_ss_step = ss_step + 2'h1;
        end
      end else begin
        next_ss_cnt = ss_cnt + SSW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ss_cnt <= '0;
      ss_step <= 2'h0;
      softstart_done <= 1'b0;
      cs_limit_mv <= `QR_LIM_MV0;
    end else begin
      ss_cnt <= next_ss_cnt;
      ss_step <= next_ss_step;
      softstart_done <= next_ss_done;
      cs_limit_mv <= lim_mv(next_ss_step);
    end
  end

  // ==========================================================
  // 48 ms feedback evaluation period
  logic [PW-1:0] per_cnt;
  logic [PW-1:0] next_per_cnt;
  qr_pkg::fb_seen_t seen;
  qr_pkg::fb_seen_t next_seen;
  qr_pkg::fb_seen_t ud_seen;
  qr_pkg::fb_seen_t next_ud_seen;
  logic ud_tick;
  logic next_ud_tick;

  always_comb begin
    next_per_cnt = per_cnt;
    next_seen = seen;
    next_ud_seen = ud_seen;
    next_ud_tick = 1'b0;
    if (running) begin
      // a crossing in the closing cycle still counts for this period
      next_seen.above_low = seen.above_low | s.fb_low;
      next_seen.above_high = seen.above_high | s.fb_high;
      next_seen.above_reset = seen.above_reset | s.fb_reset;
      if (per_cnt == PER_LAST) begin
        next_per_cnt = '0;
        next_ud_tick = 1'b1;
        next_ud_seen = next_seen;
        next_seen = '0;
      end else begin
        next_per_cnt = per_cnt + PW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      per_cnt <= '0;
      seen <= '0;
      ud_seen <= '0;
      ud_tick <= 1'b0;
      thr_line_high <= 1'b0;
    end else begin
      per_cnt <= next_per_cnt;
      seen <= next_seen;
      ud_seen <= next_ud_seen;
      ud_tick <= next_ud_tick;
      thr_line_high <= s.line_high;
    end
  end

  freq_step_counter u_ud (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .run(running),
    .tick(ud_tick),
    .seen(ud_seen),
    .force_min(s.fb_reset),
    .value(ud_value)
  );

  // ==========================================================
  // gate drive, zero-crossing count, overvoltage latch
  logic [GW-1:0] gate_cnt;
  logic [GW-1:0] next_gate_cnt;
  logic [2:0] next_zc;
  logic zc_prev;
  logic zc_edge;
  logic [OW-1:0] ovp_cnt;
  logic [OW-1:0] next_ovp_cnt;

  assign zc_edge = s.zc_below && !zc_prev;

  always_comb begin
    next_state = state;
    next_gate_cnt = (gate_cnt == '1) ? gate_cnt : gate_cnt + GW'(1);
    next_zc = zc_count;
    next_ovp_cnt = '0;
    case (state)
      qr_pkg::ST_CHARGE: begin
        if (s.supply_on) begin
          next_state = qr_pkg::ST_ON;
          next_gate_cnt = '0;
        end
      end
      qr_pkg::ST_ON: begin
        if ((gate_cnt >= LEB_LAST && s.cs_trip) || gate_cnt >= ON_LAST) begin
          next_state = qr_pkg::ST_OFF;
          next_gate_cnt = '0;
        end
      end
      qr_pkg::ST_OFF: begin
        if (s.zc_ovp) begin
          next_ovp_cnt = (ovp_cnt == BLANK_LAST) ? ovp_cnt : ovp_cnt + OW'(1);
        end
        if (zc_edge && zc_count != `QR_ZC_MAX) begin
          next_zc = zc_count + 3'h1;
        end
        if (s.zc_ovp && ovp_cnt == BLANK_LAST) begin
          next_state = qr_pkg::ST_LATCH;
        end else if (gate_cnt >= OFF_LAST) begin
          next_state = qr_pkg::ST_ON;
        end else if (gate_cnt >= RING_LAST && zc_count >= ud_value) begin
          next_state = qr_pkg::ST_ON;
        end
        if (next_state == qr_pkg::ST_ON) begin
          next_gate_cnt = '0;
          next_zc = `QR_ZC_MIN;
        end
      end
      qr_pkg::ST_LATCH: begin
        next_state = qr_pkg::ST_LATCH;
      end
      default: begin
        next_state = qr_pkg::ST_CHARGE;
        next_gate_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= qr_pkg::ST_CHARGE;
      gate_cnt <= '0;
      zc_count <= `QR_ZC_MIN;
      zc_prev <= 1'b0;
      ovp_cnt <= '0;
      startup_cell_on <= 1'b1;
      gate_drive_output <= 1'b0;
      latched_off <= 1'b0;
    end else begin
      state <= next_state;
      gate_cnt <= next_gate_cnt;
      zc_count <= next_zc;
      zc_prev <= s.zc_below;
      ovp_cnt <= next_ovp_cnt;
      startup_cell_on <= (next_state == qr_pkg::ST_CHARGE);
      gate_drive_output <= (next_state == qr_pkg::ST_ON);
      latched_off <= (next_state == qr_pkg::ST_LATCH);
    end
  end

  // ==========================================================
  // checks
  startup_hand_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_CHARGE && s.supply_on |=>
      !startup_cell_on && gate_drive_output && cs_limit_mv == `QR_LIM_MV0)
    else $error("startup handover wrong");
  ss_step_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    running && !softstart_done && ss_cnt == SS_LAST && ss_step != 2'h3 |=>
      ss_step == $past(ss_step) + 2'h1 && ss_cnt == '0)
    else $error("soft-start step not taken on time");
  ss_final_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    softstart_done |-> cs_limit_mv == `QR_LIM_MV3 && ss_step == 2'h3)
    else $error("final current limit not reached");
  period_tick_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    ud_tick |-> $past(per_cnt) == PER_LAST && per_cnt == '0)
    else $error("evaluation tick off period");
  line_thr_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    ##1 thr_line_high == $past(s.line_high))
    else $error("line threshold select lags");
  zc_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    $rose(gate_drive_output) |-> zc_count == `QR_ZC_MIN)
    else $error("zero-crossing count not cleared at turn-on");
  zc_count_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && next_state == qr_pkg::ST_OFF && zc_edge |=>
      zc_count == (($past(zc_count) == `QR_ZC_MAX) ? `QR_ZC_MAX : $past(zc_count) + 3'h1))
    else $error("zero crossing miscounted");
  zc_sat_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    zc_count == `QR_ZC_MAX && state == qr_pkg::ST_OFF && next_state == qr_pkg::ST_OFF
      |=> zc_count == `QR_ZC_MAX)
    else $error("zero-crossing count wrapped");
  valley_on_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && gate_cnt < RING_LAST && !(s.zc_ovp && ovp_cnt == BLANK_LAST)
      |=> !gate_drive_output)
    else $error("gate turned on during ringing suppression");
  valley_hit_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && gate_cnt >= RING_LAST && zc_count >= ud_value &&
      !(s.zc_ovp && ovp_cnt == BLANK_LAST) |=> gate_drive_output)
    else $error("valley reached but gate stayed off");
  max_off_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && gate_cnt == OFF_LAST && !(s.zc_ovp && ovp_cnt == BLANK_LAST)
      |=> gate_drive_output)
    else $error("maximum off-time not enforced");
  ovp_latch_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && s.zc_ovp && ovp_cnt == BLANK_LAST |=>
      latched_off && !gate_drive_output ##1 latched_off)
    else $error("overvoltage did not latch off");
  ovp_blank_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && ovp_cnt != BLANK_LAST |=> !latched_off)
    else $error("overvoltage latched before blanking ended");
  valley_wait_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_OFF && gate_cnt < OFF_LAST && zc_count < ud_value
      |=> !gate_drive_output)
    else $error("gate turned on before the selected valley");
  startup_off_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state != qr_pkg::ST_CHARGE |-> !startup_cell_on)
    else $error("startup path left on after turn-on");
  zc_on_zero_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    state == qr_pkg::ST_ON |-> zc_count == `QR_ZC_MIN)
    else $error("zero-crossing count not zero during on-time");
endmodule
`default_nettype wire

// ### qr_map.svh
// constants for the valley switch control: times, limits and levels
`ifndef QR_MAP_SVH
`define QR_MAP_SVH

`define QR_CLK_MHZ 100
`define QR_SS_TIME_US 12000
`define QR_SS_STEPS 4
`define QR_PERIOD_US 48000
`define QR_MAX_OFF_NS 50000
`define QR_MAX_ON_NS 25000
`define QR_RING_SUP_NS 2500
`define QR_LEB_NS 220
`define QR_OVP_BLANK_NS 1000

`define QR_UD_MIN 3'h1
`define QR_UD_MAX 3'h7
`define QR_ZC_MIN 3'h0
`define QR_ZC_MAX 3'h7

`define QR_LIM_MV0 10'h140
`define QR_LIM_MV1 10'h223
`define QR_LIM_MV2 10'h305
`define QR_LIM_MV3 10'h3e8

`endif

// ### qr_pkg.sv
// types shared by the valley switch control
`default_nettype none
package qr_pkg;

  typedef enum logic [3:0] {
    ST_CHARGE = 4'h1,
    ST_ON = 4'h2,
    ST_OFF = 4'h4,
    ST_LATCH = 4'h8
  } gate_state_t;

  // comparator outputs from the analog front end, all asynchronous
  typedef struct packed {
    logic supply_on;
    logic fb_low;
    logic fb_high;
    logic fb_reset;
    logic zc_below;
    logic zc_ovp;
    logic cs_trip;
    logic line_high;
  } sense_t;

  typedef struct packed {
    logic above_low;
    logic above_high;
    logic above_reset;
  } fb_seen_t;

endpackage
`default_nettype wire

// ### pin_sync.sv
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  if (W < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d_async;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ### freq_step_counter.sv
// up/down counter that picks the switch-on valley from the feedback level
`timescale 1ns/1ps
`default_nettype none
`include "qr_map.svh"
module freq_step_counter (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic tick,
  input wire qr_pkg::fb_seen_t seen,
  input wire logic force_min,
  output logic [2:0] value
);
  logic [2:0] next_value;

  always_comb begin
    next_value = value;
    if (!run || force_min) begin
      next_value = `QR_UD_MIN;
    end else if (tick) begin
      if (seen.above_reset) begin
        next_value = `QR_UD_MIN;
      end else if (seen.above_high) begin
        if (value > `QR_UD_MIN) begin
          next_value = value - 3'h1;
        end
      end else if (!seen.above_low) begin
        if (value < `QR_UD_MAX) begin
          next_value = value + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      value <= `QR_UD_MIN;
    end else begin
      value <= next_value;
    end
  end

  ud_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
    value >= `QR_UD_MIN && value <= `QR_UD_MAX)
    else $error("up/down counter left 1..7");
  ud_up_a: assert property (@(posedge mclk) disable iff (!rst_b)
    run && !force_min && tick && seen == 3'h0 |=>
      value == (($past(value) == `QR_UD_MAX) ? `QR_UD_MAX : $past(value) + 3'h1))
    else $error("counter did not step up after a quiet period");
  ud_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    run && !force_min && tick && seen == 3'h4 |=> $stable(value))
    else $error("counter changed in the hold band");
  ud_down_a: assert property (@(posedge mclk) disable iff (!rst_b)
    run && !force_min && tick && seen.above_high && !seen.above_reset |=>
      value == (($past(value) == `QR_UD_MIN) ? `QR_UD_MIN : $past(value) - 3'h1))
    else $error("counter did not step down");
  ud_force_a: assert property (@(posedge mclk) disable iff (!rst_b)
    force_min || (tick && seen.above_reset) |=> value == `QR_UD_MIN)
    else $error("reset threshold did not force the counter to one");
endmodule
`default_nettype wire

// ### power_stage_model.sv
// flyback power stage model: analog comparators as seen by the control block
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input wire logic mclk,
  input wire logic gate,
  input wire logic supply,
  input wire logic line_hi,
  input wire logic ovp,
  input wire logic [1:0] fb_lvl,
  input wire logic [4:0] valleys,
  output var qr_pkg::sense_t sense
);
  // =====================================
  // time since the gate last changed
  logic [15:0] cnt = 16'h0000;
  logic last = 1'b0;
  always @(posedge mclk) begin
    last <= gate;
    cnt <= (gate != last) ? 16'h0000 : cnt + 16'h0001;
  end
  // =====================================
  // comparator levels
  always_comb begin
    sense.supply_on = supply;
    sense.fb_low = fb_lvl >= 2'h1;
    sense.fb_high = fb_lvl >= 2'h2;
    sense.fb_reset = fb_lvl == 2'h3;
    // primary current reaches the trip level early in the on-time
    sense.cs_trip = gate && cnt >= 16'h0005;
    // damped ringing: one valley every 20 cycles, then the winding settles high
    sense.zc_below = !gate && cnt < 16'(valleys) * 16'h0014 && (cnt % 16'h0014) >= 16'h000a;
    sense.zc_ovp = !gate && ovp;
    sense.line_high = line_hi;
  end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the valley switch control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic supply = 1'b0;
  logic line_hi = 1'b0;
  logic ovp = 1'b0;
  logic [1:0] fb_lvl = 2'h0;
  logic [4:0] valleys = 5'h00;
  qr_pkg::sense_t sense;
  logic startup_cell_on, gate_drive_output, softstart_done, thr_line_high, latched_off;
  logic [9:0] cs_limit_mv;
  logic [2:0] ud_value, zc_count;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 mclk = ~mclk;

  power_stage_model stage (.mclk(mclk), .gate(gate_drive_output), .supply(supply),
    .line_hi(line_hi), .ovp(ovp), .fb_lvl(fb_lvl), .valleys(valleys), .sense(sense));

  qr_valley_switch_control #(.SS_STEP_CYC(20), .PERIOD_CYC(50), .MAX_OFF_CYC(400),
    .MAX_ON_CYC(30)) DUT (.mclk(mclk), .rst_b(rst_b), .sense(sense),
    .startup_cell_on(startup_cell_on), .gate_drive_output(gate_drive_output),
    .cs_limit_mv(cs_limit_mv), .softstart_done(softstart_done),
    .thr_line_high(thr_line_high), .latched_off(latched_off), .ud_value(ud_value),
    .zc_count(zc_count));

  // =====================================
  // shared helpers
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic timed_out(input string what);
    num_errors++;
    $display("unexpected %s: expected event seen timeout", what);
    wrap_up();
  endtask
  task automatic wait_ud(input logic [2:0] v, output int n);
    n = 0;
    while (ud_value !== v) begin
      cyc(1);
      n++;
      if (n > 3000) timed_out("ud_value");
    end
  endtask
  task automatic wait_lim(input logic [9:0] v, output int n);
    n = 0;
    while (cs_limit_mv !== v) begin
      cyc(1);
      n++;
      if (n > 3000) timed_out("cs_limit_mv");
    end
  endtask
  task automatic wait_gate(input logic v, output int n);
    n = 0;
    while (gate_drive_output !== v) begin
      cyc(1);
      n++;
      if (n > 3000) timed_out("gate_drive_output");
    end
  endtask
  // length of one off-time and the crossing count just before switch-on
  task automatic measure_off(output int len, output logic [2:0] zc);
    wait_gate(1'b0, len);
    len = 0;
    zc = zc_count;
    while (gate_drive_output !== 1'b1) begin
      zc = zc_count;
      cyc(1);
      len++;
      if (len > 3000) timed_out("gate_drive_output");
    end
  endtask

  // =====================================
  // scenarios
  task automatic t_reset();
    cyc(10);
    check("startup_cell_on", startup_cell_on, 1);
    check("gate_drive_output", gate_drive_output, 0);
    check("cs_limit_mv", cs_limit_mv, 10'h140);
    check("ud_value", ud_value, 1);
    check("zc_count", zc_count, 0);
    rst_b = 1'b1;
    $display("test reset done");
  endtask
  task automatic t_start();
    logic [9:0] lim [4];
    int n;
    lim = '{10'h140, 10'h223, 10'h305, 10'h3e8};
    cyc(20);
    check("startup_cell_on idle", startup_cell_on, 1);
    supply = 1'b1;
    wait_gate(1'b1, n);
    check("startup_cell_on", startup_cell_on, 0);
    check("cs_limit_mv start", cs_limit_mv, lim[0]);
    for (int i = 1; i < 4; i++) begin
      wait_lim(lim[i], n);
      if (i > 1) check("step length", 10'(n), 10'h014);
    end
    check("softstart_done early", softstart_done, 0);
    cyc(19);
    check("softstart_done early", softstart_done, 0);
    cyc(1);
    check("softstart_done", softstart_done, 1);
    check("cs_limit_mv final", cs_limit_mv, 10'h3e8);
    $display("test start done");
  endtask
  task automatic t_counter();
    int n;
    fb_lvl = 2'h0;
    wait_ud(3'h3, n);
    wait_ud(3'h4, n);
    check("up period", 10'(n), 10'h032);
    fb_lvl = 2'h1;
    cyc(120);
    check("ud_value hold", ud_value, 4);
    fb_lvl = 2'h0;
    wait_ud(3'h7, n);
    cyc(120);
    check("ud_value top", ud_value, 7);
    fb_lvl = 2'h2;
    wait_ud(3'h6, n);
    wait_ud(3'h5, n);
    check("down period", 10'(n), 10'h032);
    wait_ud(3'h1, n);
    cyc(120);
    check("ud_value bottom", ud_value, 1);
    fb_lvl = 2'h0;
    wait_ud(3'h4, n);
    fb_lvl = 2'h3;
    cyc(6);
    check("ud_value forced", ud_value, 1);
    fb_lvl = 2'h0;
    $display("test counter done");
  endtask
  task automatic t_valley();
    int n;
    logic [2:0] zc;
    wait_ud(3'h7, n);
    valleys = 5'h0c;
    measure_off(n, zc);
    measure_off(n, zc);
    check("zc at switch-on", zc, 7);
    check("ring end on", n >= 248 && n <= 262, 1);
    cyc(1);
    check("zc cleared", zc_count, 0);
    valleys = 5'h03;
    measure_off(n, zc);
    measure_off(n, zc);
    check("zc three", zc, 3);
    check("max off", n >= 398 && n <= 402, 1);
    $display("test valley done");
  endtask
  task automatic t_line();
    line_hi = 1'b1;
    cyc(8);
    check("thr_line_high", thr_line_high, 1);
    line_hi = 1'b0;
    cyc(8);
    check("thr_line_high low", thr_line_high, 0);
    $display("test line done");
  endtask
  task automatic t_ovp();
    int n;
    valleys = 5'h0c;
    ovp = 1'b1;
    n = 0;
    while (latched_off !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 3000) timed_out("latched_off");
    end
    check("ovp blanking", 10'(n >= 104), 10'h001);
    ovp = 1'b0;
    cyc(500);
    check("gate latched", gate_drive_output, 0);
    check("latched_off", latched_off, 1);
    $display("test ovp done");
  endtask

  initial begin
    t_reset();
    t_start();
    t_counter();
    t_valley();
    t_line();
    t_ovp();
    wrap_up();
  end
endmodule
`default_nettype wire
